/* hw/pzr_pkg.sv */
/*
 * Package for the page-zero identity and status register bank: register
 * offsets inside a page, field positions, masks of assigned bits, reset values
 * and the register-select type.
 * Assumes an 8-bit register port that carries the offset within the current page.
 */
package pzr_pkg;

	// ************************************************************
	// register offsets within a page
	// ************************************************************
	localparam logic [7:0] OFS_DIE_REV  = 8'h00;
	localparam logic [7:0] OFS_PAGE     = 8'h01;
	localparam logic [7:0] OFS_PART_LO  = 8'h02;
	localparam logic [7:0] OFS_PART_HI  = 8'h03;
	localparam logic [7:0] OFS_GRADE    = 8'h04;
	localparam logic [7:0] OFS_SI_REV   = 8'h05;
	localparam logic [7:0] OFS_TEMP     = 8'h09;
	localparam logic [7:0] OFS_PACKAGE  = 8'h0a;
	localparam logic [7:0] OFS_BUS_ADDR = 8'h0b;
	localparam logic [7:0] OFS_LIVE_DEV = 8'h0c;
	localparam logic [7:0] OFS_LIVE_IN  = 8'h0d;
	localparam logic [7:0] OFS_LIVE_PLL = 8'h0e;
	localparam logic [7:0] OFS_FLAG_DEV = 8'h11;
	localparam logic [7:0] OFS_FLAG_IN  = 8'h12;
	localparam logic [7:0] OFS_FLAG_PLL = 8'h13;

	// ************************************************************
	// pages, fixed codes and reset values
	// ************************************************************
	localparam logic [7:0] PAGE_RESET      = 8'h00;
	localparam logic [7:0] PAGE_ZERO       = 8'h00;
	localparam logic [7:0] TEMP_INDUSTRIAL = 8'h00;
	localparam logic [7:0] PKG_QFN64       = 8'h00;
	localparam logic [7:0] READ_IDLE       = 8'h00;

	// ************************************************************
	// status field positions
	// ************************************************************
	localparam int BIT_CALIBRATING   = 0;
	localparam int BIT_REF_PINS_LOST = 1;
	localparam int BIT_REF_UNDETECT  = 2;
	localparam int BIT_REF_LOCK_PROB = 3;
	localparam int BIT_BUS_TIMEOUT   = 5;
	localparam int BIT_PLL_UNLOCKED  = 1;
	localparam int BIT_PLL_COASTING  = 5;
	localparam int LSB_SIGNAL_LOST   = 0;
	localparam int LSB_OFF_FREQ      = 4;
	localparam int NUM_INPUTS        = 4;

	// ************************************************************
	// status register slots and their assigned bits
	// ************************************************************
	localparam int STAT_REGS = 3;
	localparam int SLOT_DEV  = 0;
	localparam int SLOT_IN   = 1;
	localparam int SLOT_PLL  = 2;
	localparam logic [7:0] MASK_DEV = 8'h2f;
	localparam logic [7:0] MASK_IN  = 8'hff;
	localparam logic [7:0] MASK_PLL = 8'h22;
	localparam logic [STAT_REGS-1:0][7:0] STAT_MASK = {MASK_PLL, MASK_IN, MASK_DEV};

	// async monitor inputs passed through the synchroniser
	localparam int MON_BITS = 16;

	typedef enum {
		SEL_NONE, SEL_PAGE, SEL_DIE_REV, SEL_PART_LO, SEL_PART_HI, SEL_GRADE,
		SEL_SI_REV, SEL_TEMP, SEL_PACKAGE, SEL_BUS_ADDR, SEL_LIVE_DEV,
		SEL_LIVE_IN, SEL_LIVE_PLL, SEL_FLAG_DEV, SEL_FLAG_IN, SEL_FLAG_PLL
	} pzr_sel_t;

endpackage : pzr_pkg

/* hw/pzr_flag_if.sv */
/*
 * Interface between the register bank and its sticky-flag bank: live status,
 * sticky flags and the clear request from a register write.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ns
`default_nettype none

interface pzr_flag_if;
	import pzr_pkg::*;

	logic [STAT_REGS-1:0][7:0] live;
	logic [STAT_REGS-1:0][7:0] flag;
	logic [STAT_REGS-1:0]      clrEn;
	logic [7:0]                clrData;

	modport regs  (output live, output clrEn, output clrData, input flag);
	modport flags (input live, input clrEn, input clrData, output flag);

endinterface : pzr_flag_if

`default_nettype wire

/* hw/pzr_sync_bank.sv */
/*
 * Two-flop synchroniser bank for asynchronous monitor levels.
 * Assumes levels that stay stable for several clock periods; pulses shorter
 * than a clock may be missed.
 */
`timescale 1ns/1ns
`default_nettype none

module pzr_sync_bank #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1  <= '0;
			syncOut <= '0;
		end else begin
			stage1  <= asyncIn;
			syncOut <= stage1;
		end
	end

endmodule : pzr_sync_bank

`default_nettype wire

/* hw/pzr_sticky_flags.sv */
/*
 * Sticky companions of the live status bits. A live 1 sets the flag; a write
 * of 0 clears it only while the live bit is 0.
 * Assumes live bits already synchronised to clk.
 */
`timescale 1ns/1ns
`default_nettype none

module pzr_sticky_flags import pzr_pkg::*; (
	// clock and reset
	input  wire logic    clk,
	input  wire logic    rst_n,
	// status exchange
	pzr_flag_if.flags    fl
);

	logic [STAT_REGS-1:0][7:0] flag;
	logic [STAT_REGS-1:0][7:0] next_flag;

	genvar i;
	generate
		for (i = 0; i < STAT_REGS; i++) begin : g_slot
			logic [7:0] clearMask;
			// set wins: a live 1 holds the flag even during a clear
			always_comb begin
				clearMask    = fl.clrEn[i] ? (~fl.clrData & ~fl.live[i]) : 8'h00;
				next_flag[i] = ((flag[i] & ~clearMask) | fl.live[i]) & STAT_MASK[i];
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= '0;
		end else begin
			flag <= next_flag;
		end
	end

	assign fl.flag = flag;

endmodule : pzr_sticky_flags

`default_nettype wire

/* hw/pzr_page0_regs.sv */
/*
 * Page-zero register bank of a clock synthesizer: page select mirrored on
 * every page, identification bytes, live status and their sticky flags.
 * Assumes a serial-port front end that presents one register access per
 * cycle as an offset within the current page, and a bus-timeout level that
 * comes from that front end on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module pzr_page0_regs import pzr_pkg::*; #(
	// identity values; all defaults arbitrary
	parameter logic [3:0]  DIE_REVISION   = 4'h1,
	parameter logic [15:0] PART_DIGITS    = 16'h1234,
	parameter logic [7:0]  GRADE_INDEX    = 8'h01,
	parameter logic [7:0]  SI_REV_INDEX   = 8'h02,
	parameter logic [4:0]  BUS_ADDR_UPPER = 5'h1a
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// register port
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	input  wire logic [7:0] regWdata,
	output logic      [7:0] regRdata,
	output logic            regRdValid,
	output logic      [7:0] activePage,
	// device monitors, asynchronous
	input  wire logic       calibratingNow,
	input  wire logic       refPinsNoSignal,
	input  wire logic       refSignalUndetected,
	input  wire logic       refLockProblem,
	input  wire logic [3:0] inputSignalLost,
	input  wire logic [3:0] inputOffFrequency,
	input  wire logic       pllUnlocked,
	input  wire logic       pllCoasting,
	// serial front end, same clock
	input  wire logic       busTimeoutErr,
	// address straps, asynchronous
	input  wire logic       addrStrapHigh,
	input  wire logic       addrStrapLow
);

	// ************************************************************
	// reset release
	// ************************************************************
	logic [1:0] rstPipe;
	logic       rst_n;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstPipe <= 2'b00;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end

	assign rst_n = rstPipe[1];

	// ************************************************************
	// monitor synchronisation
	// ************************************************************
	logic [MON_BITS-1:0] monAsync;
	logic [MON_BITS-1:0] monSync;
	logic [1:0]          strapAsync;
	logic [1:0]          strapSync;

	assign monAsync = {pllCoasting, pllUnlocked, inputOffFrequency, inputSignalLost,
		2'b00, refLockProblem, refSignalUndetected, refPinsNoSignal, calibratingNow};
	assign strapAsync = {addrStrapHigh, addrStrapLow};

	pzr_sync_bank #(
		.WIDTH (MON_BITS)
	) u_mon_sync (
		.clk     (sys_clk),
		.rst_n   (rst_n),
		.asyncIn (monAsync),
		.syncOut (monSync)
	);

	pzr_sync_bank #(
		.WIDTH (2)
	) u_strap_sync (
		.clk     (sys_clk),
		.rst_n   (rst_n),
		.asyncIn (strapAsync),
		.syncOut (strapSync)
	);

	// ************************************************************
	// live status assembly
	// ************************************************************
	pzr_flag_if flagBus ();

	logic [7:0] liveDev;
	logic [7:0] liveIn;
	logic [7:0] livePll;

	always_comb begin
		liveDev                    = 8'h00;
		liveDev[BIT_CALIBRATING]   = monSync[0];
		liveDev[BIT_REF_PINS_LOST] = monSync[1];
		liveDev[BIT_REF_UNDETECT]  = monSync[2];
		liveDev[BIT_REF_LOCK_PROB] = monSync[3];
		liveDev[BIT_BUS_TIMEOUT]   = busTimeoutErr;
		liveIn                     = 8'h00;
		liveIn[LSB_SIGNAL_LOST +: NUM_INPUTS] = monSync[9:6];
		liveIn[LSB_OFF_FREQ +: NUM_INPUTS]    = monSync[13:10];
		livePll                    = 8'h00;
		livePll[BIT_PLL_UNLOCKED]  = monSync[14];
		livePll[BIT_PLL_COASTING]  = monSync[15];
	end

	assign flagBus.live[SLOT_DEV] = liveDev;
	assign flagBus.live[SLOT_IN]  = liveIn;
	assign flagBus.live[SLOT_PLL] = livePll;

	pzr_sticky_flags u_flags (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.fl    (flagBus.flags)
	);

	// ************************************************************
	// address decode
	// ************************************************************
	// page select answers on every page; everything else only on page zero
	function automatic pzr_sel_t regDecode(input logic [7:0] page, input logic [7:0] ofs);
		pzr_sel_t sel;
		sel = SEL_NONE;
		if (ofs == OFS_PAGE) begin
			sel = SEL_PAGE;
		end else if (page == PAGE_ZERO) begin
			case (ofs)
				OFS_DIE_REV:  sel = SEL_DIE_REV;
				OFS_PART_LO:  sel = SEL_PART_LO;
				OFS_PART_HI:  sel = SEL_PART_HI;
				OFS_GRADE:    sel = SEL_GRADE;
				OFS_SI_REV:   sel = SEL_SI_REV;
				OFS_TEMP:     sel = SEL_TEMP;
				OFS_PACKAGE:  sel = SEL_PACKAGE;
				OFS_BUS_ADDR: sel = SEL_BUS_ADDR;
				OFS_LIVE_DEV: sel = SEL_LIVE_DEV;
				OFS_LIVE_IN:  sel = SEL_LIVE_IN;
				OFS_LIVE_PLL: sel = SEL_LIVE_PLL;
				OFS_FLAG_DEV: sel = SEL_FLAG_DEV;
				OFS_FLAG_IN:  sel = SEL_FLAG_IN;
				OFS_FLAG_PLL: sel = SEL_FLAG_PLL;
				default:      sel = SEL_NONE;
			endcase
		end
		return sel;
	endfunction : regDecode

	pzr_sel_t rdSel;
	pzr_sel_t wrSel;

	assign rdSel = regDecode(activePage, regAddr);
	assign wrSel = regDecode(activePage, regAddr);

	// ************************************************************
	// write side
	// ************************************************************
	logic [7:0] next_page;

	always_comb begin
		next_page = activePage;
		// only page select is stored here; flag writes clear sticky bits, identity and live writes fall through
		if (regWrite && wrSel == SEL_PAGE) begin
			next_page = regWdata;
		end
	end

	assign flagBus.clrEn[SLOT_DEV] = regWrite && wrSel == SEL_FLAG_DEV;
	assign flagBus.clrEn[SLOT_IN]  = regWrite && wrSel == SEL_FLAG_IN;
	assign flagBus.clrEn[SLOT_PLL] = regWrite && wrSel == SEL_FLAG_PLL;
	assign flagBus.clrData         = regWdata;

	// ************************************************************
	// strap capture
	// ************************************************************
	// straps sampled once after reset so the address cannot move mid-transfer
	logic [1:0] strapAddr;
	logic       strapTaken;
	logic [1:0] strapFill;
	logic [1:0] next_strapAddr;
	logic       next_strapTaken;
	logic [1:0] next_strapFill;

	always_comb begin
		next_strapAddr  = strapAddr;
		next_strapTaken = strapTaken;
		next_strapFill  = {strapFill[0], 1'b1};
		// synchroniser still shows its reset value for two edges after release
		if (strapFill[1] && !strapTaken) begin
			next_strapAddr  = strapSync;
			next_strapTaken = 1'b1;
		end
	end

	// ************************************************************
	// read side
	// ************************************************************
	logic [7:0] next_rdata;
	logic       next_rdValid;

	always_comb begin
		next_rdata   = regRdata;
		next_rdValid = regRead;
		if (regRead) begin
			unique case (rdSel)
				SEL_PAGE:     next_rdata = activePage;
				SEL_DIE_REV:  next_rdata = {4'h0, DIE_REVISION};
				SEL_PART_LO:  next_rdata = PART_DIGITS[7:0];
				SEL_PART_HI:  next_rdata = PART_DIGITS[15:8];
				SEL_GRADE:    next_rdata = GRADE_INDEX;
				SEL_SI_REV:   next_rdata = SI_REV_INDEX;
				SEL_TEMP:     next_rdata = TEMP_INDUSTRIAL;
				SEL_PACKAGE:  next_rdata = PKG_QFN64;
				SEL_BUS_ADDR: next_rdata = {1'b0, BUS_ADDR_UPPER, strapAddr};
				SEL_LIVE_DEV: next_rdata = liveDev & MASK_DEV;
				SEL_LIVE_IN:  next_rdata = liveIn & MASK_IN;
				SEL_LIVE_PLL: next_rdata = livePll & MASK_PLL;
				SEL_FLAG_DEV: next_rdata = flagBus.flag[SLOT_DEV];
				SEL_FLAG_IN:  next_rdata = flagBus.flag[SLOT_IN];
				SEL_FLAG_PLL: next_rdata = flagBus.flag[SLOT_PLL];
				SEL_NONE:     next_rdata = READ_IDLE;
			endcase
		end
	end

	// ************************************************************
	// state registers
	// ************************************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			activePage <= PAGE_RESET;
			regRdata   <= READ_IDLE;
			regRdValid <= 1'b0;
			strapAddr  <= 2'b00;
			strapTaken <= 1'b0;
			strapFill  <= 2'b00;
		end else begin
			activePage <= next_page;
			regRdata   <= next_rdata;
			regRdValid <= next_rdValid;
			strapAddr  <= next_strapAddr;
			strapTaken <= next_strapTaken;
			strapFill  <= next_strapFill;
		end
	end

endmodule : pzr_page0_regs

`default_nettype wire

/* sim/pzr_page0_regs_props.sv */
/* checker for the page-zero register bank, on its top ports only
   assumes at most one register access per cycle and no read during reset */
`timescale 1ns/1ns
`default_nettype none
module pzr_page0_regs_props import pzr_pkg::*; (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       reset_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic       regRdValid,
	input wire logic [7:0] activePage,
	// same-clock monitor
	input wire logic       busTimeoutErr
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic rdZero;
	assign rdZero = regRead && !regWrite && activePage == PAGE_ZERO;
	property p_valid_follows; regRead |=> regRdValid; endproperty
	a_valid_follows: assert property (p_valid_follows) else $error("no valid after read");
	property p_valid_cause; regRdValid |-> $past(regRead); endproperty
	a_valid_cause: assert property (p_valid_cause) else $error("valid without read");
	property p_page_write; regWrite && regAddr == OFS_PAGE |=> activePage == $past(regWdata);
	endproperty
	a_page_write: assert property (p_page_write) else $error("page not switched");
	property p_page_hold; !(regWrite && regAddr == OFS_PAGE) |=> $stable(activePage); endproperty
	a_page_hold: assert property (p_page_hold) else $error("page moved");
	property p_page_read;
		regRead && !regWrite && regAddr == OFS_PAGE |=> regRdata == $past(activePage);
	endproperty
	a_page_read: assert property (p_page_read) else $error("page readback wrong");
	property p_die_upper; rdZero && regAddr == OFS_DIE_REV |=> regRdata[7:4] == 4'h0; endproperty
	a_die_upper: assert property (p_die_upper) else $error("die byte upper bits set");
	property p_fixed_codes;
		rdZero && (regAddr == OFS_TEMP || regAddr == OFS_PACKAGE) |=> regRdata == 8'h00;
	endproperty
	a_fixed_codes: assert property (p_fixed_codes) else $error("fixed code wrong");
	property p_other_page;
		regRead && activePage != PAGE_ZERO && regAddr != OFS_PAGE |=> regRdata == 8'h00;
	endproperty
	a_other_page: assert property (p_other_page) else $error("other page not zero");
	property p_dev_mask; rdZero && regAddr == OFS_LIVE_DEV |=> (regRdata & ~MASK_DEV) == 8'h00;
	endproperty
	a_dev_mask: assert property (p_dev_mask) else $error("unassigned bit set");
	property p_timeout_bit;
		busTimeoutErr [*4] ##0 (rdZero && regAddr == OFS_LIVE_DEV) |=> regRdata[BIT_BUS_TIMEOUT];
	endproperty
	a_timeout_bit: assert property (p_timeout_bit) else $error("timeout bit missing");
	property p_rdata_hold; !regRead |=> $stable(regRdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule : pzr_page0_regs_props
bind pzr_page0_regs pzr_page0_regs_props props_u (.sys_clk(sys_clk), .reset_n(reset_n),
	.regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
	.regRdata(regRdata), .regRdValid(regRdValid), .activePage(activePage),
	.busTimeoutErr(busTimeoutErr));
`default_nettype wire

/* sim/pzr_host_model.sv */
/* host side of the register port: single-cycle write and read strobes
   assumes the bank answers a read with a one-cycle valid */
`timescale 1ns/1ns
`default_nettype none
module pzr_host_model (
	// clock
	input wire logic       sys_clk,
	// answer
	input wire logic [7:0] regRdata,
	input wire logic       regRdValid,
	// request
	output logic     [7:0] regAddr,
	output logic           regWrite,
	output logic           regRead,
	output logic     [7:0] regWdata
);
	initial begin
		regAddr = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWdata = 8'h00;
	end
	// idle address and data flipped so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		regAddr <= ~a;
		regWdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		regAddr <= ~a;
		ok = 1'b0;
		d = 8'h00;
		for (int i = 0; i < 4 && !ok; i++) begin
			#1;
			if (regRdValid === 1'b1) begin
				ok = 1'b1;
				d = regRdata;
			end else
				@(posedge sys_clk);
		end
	endtask : rd
endmodule : pzr_host_model
`default_nettype wire

/* sim/pzr_page0_regs_test.sv */
/* self-checking bench for the page-zero register bank
   assumes the host model and the bound checker sit beside it */
`timescale 1ns/1ns
`default_nettype none
module pzr_page0_regs_test import pzr_pkg::*; ;
	// identity values for this run, all arbitrary
	localparam logic [3:0]  DIE   = 4'h7;
	localparam logic [15:0] PART  = 16'h4821;
	localparam logic [7:0]  GRADE = 8'h02;
	localparam logic [7:0]  SIREV = 8'h03;
	localparam logic [4:0]  UPPER = 5'h0b;
	logic        sys_clk;
	logic        reset_n;
	logic [14:0] mon;
	logic [1:0]  strap;
	logic [7:0]  regAddr;
	logic [7:0]  regWdata;
	logic [7:0]  regRdata;
	logic [7:0]  activePage;
	logic        regWrite;
	logic        regRead;
	logic        regRdValid;
	int          bad_count;
	int          checked;
	pzr_host_model host_u (.sys_clk, .regRdata, .regRdValid, .regAddr, .regWrite, .regRead,
		.regWdata);
	pzr_page0_regs #(.DIE_REVISION(DIE), .PART_DIGITS(PART), .GRADE_INDEX(GRADE),
		.SI_REV_INDEX(SIREV), .BUS_ADDR_UPPER(UPPER)) dut_u (.sys_clk, .reset_n, .regAddr,
		.regWrite, .regRead, .regWdata, .regRdata, .regRdValid, .activePage,
		.calibratingNow(mon[0]), .refPinsNoSignal(mon[1]), .refSignalUndetected(mon[2]),
		.refLockProblem(mon[3]), .busTimeoutErr(mon[4]), .inputSignalLost(mon[8:5]),
		.inputOffFrequency(mon[12:9]), .pllUnlocked(mon[13]), .pllCoasting(mon[14]),
		.addrStrapHigh(strap[1]), .addrStrapLow(strap[0]));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// ****************************************
	// checking helpers
	// ****************************************
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string w);
		logic [7:0] d;
		logic       ok;
		host_u.rd(a, d, ok);
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected %s expected valid seen none", w);
			tally_and_finish();
		end else begin
			chk(w, e, d);
		end
	endtask : rdc
	task automatic settle();
		repeat (5) @(posedge sys_clk);
	endtask : settle
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_ident();
		rdc(OFS_PAGE, PAGE_RESET, "page");
		rdc(OFS_DIE_REV, {4'h0, DIE}, "die");
		host_u.wr(OFS_DIE_REV, 8'hff);
		rdc(OFS_DIE_REV, {4'h0, DIE}, "die after write");
		rdc(OFS_PART_LO, PART[7:0], "part low");
		rdc(OFS_PART_HI, PART[15:8], "part high");
		rdc(OFS_GRADE, GRADE, "grade");
		rdc(OFS_SI_REV, SIREV, "revision");
		rdc(OFS_TEMP, TEMP_INDUSTRIAL, "temp");
		rdc(OFS_PACKAGE, PKG_QFN64, "package");
		rdc(OFS_BUS_ADDR, {1'b0, UPPER, 2'b10}, "bus addr");
		rdc(8'h06, 8'h00, "unmapped");
		$display("test ident done");
	endtask : t_ident
	task automatic t_status();
		logic [14:0] m;
		for (int i = 0; i < 16; i++) begin
			m = (i == 15) ? 15'h7fff : 15'h0001 << i;
			@(posedge sys_clk);
			mon <= m;
			settle();
			host_u.wr(OFS_LIVE_DEV, 8'h00);
			rdc(OFS_LIVE_DEV, {2'b00, m[4], 1'b0, m[3:0]}, "dev");
			rdc(OFS_LIVE_IN, m[12:5], "inputs");
			rdc(OFS_LIVE_PLL, {2'b00, m[14], 3'b000, m[13], 1'b0}, "pll");
		end
		$display("test status done");
	endtask : t_status
	task automatic t_flags();
		@(posedge sys_clk);
		mon <= 15'h0080;
		settle();
		rdc(OFS_FLAG_IN, 8'hff, "flag in set");
		host_u.wr(OFS_FLAG_IN, 8'h00);
		rdc(OFS_FLAG_IN, 8'h04, "flag in live kept");
		host_u.wr(OFS_FLAG_DEV, 8'h00);
		rdc(OFS_FLAG_DEV, 8'h00, "flag dev");
		host_u.wr(OFS_FLAG_PLL, 8'h00);
		rdc(OFS_FLAG_PLL, 8'h00, "flag pll");
		@(posedge sys_clk);
		mon <= 15'h0000;
		settle();
		host_u.wr(OFS_FLAG_IN, 8'h00);
		rdc(OFS_FLAG_IN, 8'h00, "flag in cleared");
		$display("test flags done");
	endtask : t_flags
	task automatic t_paging();
		host_u.wr(OFS_PAGE, 8'h05);
		rdc(OFS_PAGE, 8'h05, "page 5");
		rdc(OFS_DIE_REV, 8'h00, "page 5 die");
		host_u.wr(OFS_PAGE, 8'hff);
		// page register updates at the write edge; look once it has settled
		@(negedge sys_clk);
		chk("active page", 8'hff, activePage);
		rdc(OFS_PAGE, 8'hff, "page ff");
		rdc(OFS_PART_LO, 8'h00, "page ff part");
		host_u.wr(OFS_PAGE, PAGE_ZERO);
		rdc(OFS_PART_LO, PART[7:0], "page 0 part");
		host_u.wr(OFS_PAGE, 8'h03);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		strap <= 2'b01;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		settle();
		rdc(OFS_PAGE, PAGE_RESET, "page after reset");
		rdc(OFS_BUS_ADDR, {1'b0, UPPER, 2'b01}, "bus addr after reset");
		$display("test paging done");
	endtask : t_paging
	initial begin
		reset_n = 1'b0;
		mon = 15'h0000;
		strap = 2'b10;
		bad_count = 0;
		checked = 0;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		settle();
		t_ident();
		t_status();
		t_flags();
		t_paging();
		tally_and_finish();
	end
endmodule : pzr_page0_regs_test
`default_nettype wire
